// file: verilog/sermode_pkg.sv
package sermode_pkg;

  // Feature disable register bit positions
  localparam int FEAT_EDH_BIT    = 0;
  localparam int FEAT_PID_BIT    = 1;
  localparam int FEAT_ANC_BIT    = 2;
  localparam int FEAT_CRC_BIT    = 3;
  localparam int FEAT_LN_BIT     = 4;
  localparam int FEAT_TRS_BIT    = 5;
  localparam int FEAT_REMAP_BIT  = 6;
  localparam int FEAT_W          = 7;

  // Register offsets on the plain register port
  localparam logic [3:0] OFS_FEATURE_DISABLE = 4'h0;
  localparam logic [3:0] OFS_MODE_STATUS     = 4'h1;
  localparam logic [3:0] OFS_FEATURE_ACTIVE  = 4'h2;

  localparam logic [FEAT_W-1:0] FEATURE_DISABLE_RST = 7'h00;

  localparam int WORD_W     = 20;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [1:0] {
    MODE_THROUGH,
    MODE_SMPTE,
    MODE_ASI
  } op_mode_t;

  // Synchronised static control pins
  typedef struct packed {
    logic asi_transport_select;
    logic line_rate_select;
    logic input_width_select;
    logic processing_master_enable;
    logic video_coding_enable;
    logic serial_out_enable;
    logic test_host_select;
  } ctrl_pins_t;

  // Decoded configuration handed to the datapath
  typedef struct packed {
    op_mode_t          mode;
    logic              rate_sd;
    logic              wide_bus;
    logic              scramble_en;
    logic              asi_encode_en;
    logic              slew_sd;
    logic              out_drive;
    logic              host_port_sel;
    logic [FEAT_W-1:0] feat_active;
  } mode_cfg_t;

  typedef struct packed {
    logic              valid;
    logic [WORD_W-1:0] data;
  } word_t;

endpackage : sermode_pkg

// file: verilog/word_fifo.sv
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
    logic                        out_valid;
    logic [WIDTH-1:0]            out_data;
  } fifo_state_t;

  fifo_state_t st_reg;
  fifo_state_t st_next;
  logic        push;
  logic        pop;

  always_comb begin
    st_next = st_reg;
    pop     = st_reg.count != '0 && (!st_reg.out_valid || out_ready);
    push    = in_valid && st_reg.count != (AW+1)'(DEPTH);
    if (out_ready) begin
      st_next.out_valid = 1'b0;
    end
    // Output stage is a flop so the consumer sees registered data
    if (pop) begin
      st_next.out_valid = 1'b1;
      st_next.out_data  = st_reg.mem[st_reg.rptr];
      st_next.rptr      = st_reg.rptr + 1'b1;
    end
    if (push) begin
      st_next.mem[st_reg.wptr] = in_data;
      st_next.wptr             = st_reg.wptr + 1'b1;
    end
    st_next.count = st_reg.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign in_ready  = st_reg.count != (AW+1)'(DEPTH);
  assign out_valid = st_reg.out_valid;
  assign out_data  = st_reg.out_data;

endmodule : word_fifo

// file: verilog/serializer_mode_control.sv
`timescale 1ns/1ps
module serializer_mode_control (
  input  wire logic                                mclk,
  input  wire logic                                rst,
  input  wire logic                                asi_transport_select,
  input  wire logic                                line_rate_select,
  input  wire logic                                input_width_select,
  input  wire logic                                processing_master_enable,
  input  wire logic                                video_coding_enable,
  input  wire logic                                serial_out_enable,
  input  wire logic                                test_host_select,
  input  wire logic [3:0]                          reg_addr,
  input  wire logic [31:0]                         reg_wdata,
  input  wire logic                                reg_wr,
  input  wire logic                                reg_rd,
  output logic [31:0]                              reg_rdata,
  input  wire logic                                pin_valid,
  output logic                                     pin_ready,
  input  wire logic [sermode_pkg::WORD_W-1:0]      pin_data,
  output sermode_pkg::word_t                       ser_word,
  input  wire logic                                ser_ready,
  output sermode_pkg::mode_cfg_t                   cfg,
  output logic                                     serial_out_pair_o,
  output logic                                     serial_out_pair_oe
);

  typedef struct packed {
    sermode_pkg::ctrl_pins_t         meta;
    sermode_pkg::ctrl_pins_t         pins;
    logic [sermode_pkg::FEAT_W-1:0]  feature_disable_reg;
    logic [31:0]                     rdata;
    sermode_pkg::mode_cfg_t          cfg;
    sermode_pkg::word_t              word;
    logic                            in_ready;
    logic                            out_bit;
    logic                            out_oe;
  } top_state_t;

  top_state_t st_reg;
  top_state_t st_next;

  logic                             f_valid;
  logic [sermode_pkg::WORD_W-1:0]   f_data;
  logic                             f_in_ready;
  logic                             f_take;

  function automatic sermode_pkg::op_mode_t decode_mode(
    input sermode_pkg::ctrl_pins_t p
  );
    if (p.asi_transport_select && p.line_rate_select && !p.video_coding_enable) begin
      return sermode_pkg::MODE_ASI;
    end else if (p.video_coding_enable && !p.asi_transport_select) begin
      return sermode_pkg::MODE_SMPTE;
    end else begin
      // Illegal combinations fall back to uncoded pass-through
      return sermode_pkg::MODE_THROUGH;
    end
  endfunction : decode_mode

  function automatic logic [sermode_pkg::FEAT_W-1:0] feature_mask(
    input sermode_pkg::ctrl_pins_t   p,
    input sermode_pkg::op_mode_t     m,
    input logic [sermode_pkg::FEAT_W-1:0] dis
  );
    logic [sermode_pkg::FEAT_W-1:0] f;
    f = '0;
    if (p.processing_master_enable && m == sermode_pkg::MODE_SMPTE) begin
      f = ~dis;
      if (!p.line_rate_select) begin
        f[sermode_pkg::FEAT_EDH_BIT] = 1'b0;
      end else begin
        f[sermode_pkg::FEAT_CRC_BIT] = 1'b0;
        f[sermode_pkg::FEAT_LN_BIT]  = 1'b0;
      end
    end
    return f;
  endfunction : feature_mask

  word_fifo #(
    .WIDTH (sermode_pkg::WORD_W),
    .DEPTH (sermode_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (pin_valid),
    .in_ready  (f_in_ready),
    .in_data   (pin_data),
    .out_valid (f_valid),
    .out_ready (f_take),
    .out_data  (f_data)
  );

  // Output word stage stalls on serializer back-pressure
  assign f_take = !st_reg.word.valid || ser_ready;

  always_comb begin
    st_next      = st_reg;
    // Static pins still cross domains, so two flops first
    st_next.meta = '{asi_transport_select, line_rate_select, input_width_select,
                     processing_master_enable, video_coding_enable,
                     serial_out_enable, test_host_select};
    st_next.pins = st_reg.meta;
    st_next.in_ready = f_in_ready;

    st_next.cfg.mode          = decode_mode(st_reg.pins);
    st_next.cfg.rate_sd       = st_reg.pins.line_rate_select;
    st_next.cfg.slew_sd       = st_reg.pins.line_rate_select;
    st_next.cfg.wide_bus      = (st_next.cfg.mode != sermode_pkg::MODE_ASI) &&
                                st_reg.pins.input_width_select;
    st_next.cfg.scramble_en   = st_next.cfg.mode == sermode_pkg::MODE_SMPTE;
    st_next.cfg.asi_encode_en = st_next.cfg.mode == sermode_pkg::MODE_ASI;
    st_next.cfg.out_drive     = st_reg.pins.serial_out_enable;
    st_next.cfg.host_port_sel = !st_reg.pins.test_host_select;
    st_next.cfg.feat_active   = feature_mask(st_reg.pins, st_next.cfg.mode,
                                             st_reg.feature_disable_reg);

    if (f_take) begin
      st_next.word.valid = f_valid;
      // Narrow bus keeps only the low 10 bits; upper half forced zero
      st_next.word.data  = st_reg.cfg.wide_bus ? f_data : {10'h000, f_data[9:0]};
    end

    if (reg_wr && reg_addr == sermode_pkg::OFS_FEATURE_DISABLE) begin
      st_next.feature_disable_reg = reg_wdata[sermode_pkg::FEAT_W-1:0];
    end

    st_next.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        sermode_pkg::OFS_FEATURE_DISABLE:
          st_next.rdata = {25'h000_0000, st_reg.feature_disable_reg};
        sermode_pkg::OFS_MODE_STATUS:
          st_next.rdata = {24'h00_0000, st_reg.cfg.host_port_sel, st_reg.cfg.out_drive,
                           st_reg.cfg.asi_encode_en, st_reg.cfg.scramble_en,
                           st_reg.cfg.wide_bus, st_reg.cfg.rate_sd, st_reg.cfg.mode};
        sermode_pkg::OFS_FEATURE_ACTIVE:
          st_next.rdata = {25'h000_0000, st_reg.cfg.feat_active};
        default:
          st_next.rdata = '0;
      endcase
    end

    // Line model: drive bit 0 of the output word when enabled, float otherwise
    st_next.out_oe  = st_reg.cfg.out_drive;
    st_next.out_bit = st_reg.cfg.out_drive & st_reg.word.data[0];
  end

  // Reset returns every control bit to default
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg                     <= '0;
      st_reg.feature_disable_reg <= sermode_pkg::FEATURE_DISABLE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata          = st_reg.rdata;
  assign pin_ready          = st_reg.in_ready;
  assign ser_word           = st_reg.word;
  assign cfg                = st_reg.cfg;
  assign serial_out_pair_o  = st_reg.out_bit;
  assign serial_out_pair_oe = st_reg.out_oe;

endmodule : serializer_mode_control

// file: sim/sermode_properties.sv
`timescale 1ns/1ps
module sermode_properties (
  input logic                   mclk,
  input logic                   rst,
  input logic                   asi_transport_select,
  input logic                   line_rate_select,
  input logic                   input_width_select,
  input logic                   processing_master_enable,
  input logic                   video_coding_enable,
  input logic                   serial_out_enable,
  input logic                   test_host_select,
  input sermode_pkg::word_t     ser_word,
  input logic                   ser_ready,
  input sermode_pkg::mode_cfg_t cfg,
  input logic                   serial_out_pair_oe
);
  // Pins three edges back, the depth of sync plus decode
  sermode_pkg::ctrl_pins_t p1_reg, p2_reg, p_reg;
  logic [2:0]              up_reg;
  logic                    ok;
  always_ff @(posedge mclk) begin
    p1_reg <= {asi_transport_select, line_rate_select, input_width_select,
      processing_master_enable, video_coding_enable, serial_out_enable, test_host_select};
    p2_reg <= p1_reg;
    p_reg  <= p2_reg;
  end
  // Pipeline holds stale pins until refilled after reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      up_reg <= 3'h0;
    end else if (!ok) begin
      up_reg <= up_reg + 3'h1;
    end
  end
  assign ok = up_reg[2];
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence stall_s;
    ser_word.valid && !ser_ready;
  endsequence
  asi_mode_a: assert property (ok |->
    (cfg.mode == 2'h2) == (p_reg.asi_transport_select && p_reg.line_rate_select
    && !p_reg.video_coding_enable) && cfg.asi_encode_en == (cfg.mode == 2'h2))
    else $error("transport decode wrong");
  smpte_mode_a: assert property (ok |->
    (cfg.mode == 2'h1) == (p_reg.video_coding_enable && !p_reg.asi_transport_select))
    else $error("coded mode decode wrong");
  bypass_a: assert property (ok && !p_reg.video_coding_enable |->
    cfg.mode != 2'h1 && !cfg.scramble_en && cfg.feat_active == 7'h00)
    else $error("bypass still codes");
  rate_a: assert property (ok |->
    cfg.rate_sd == p_reg.line_rate_select && cfg.slew_sd == p_reg.line_rate_select)
    else $error("rate or slew wrong");
  width_a: assert property (ok && cfg.mode != 2'h2 |->
    cfg.wide_bus == p_reg.input_width_select) else $error("bus width wrong");
  feat_off_a: assert property (ok && !p_reg.processing_master_enable |->
    cfg.feat_active == 7'h00) else $error("feature on without master");
  feat_rate_a: assert property (ok && |cfg.feat_active |->
    !(cfg.rate_sd ? cfg.feat_active[3] || cfg.feat_active[4] : cfg.feat_active[0]))
    else $error("feature at wrong rate");
  drive_a: assert property (ok && $stable(cfg.out_drive) |->
    serial_out_pair_oe == cfg.out_drive && cfg.out_drive == p_reg.serial_out_enable)
    else $error("output enable wrong");
  host_a: assert property (ok |-> cfg.host_port_sel == !p_reg.test_host_select)
    else $error("port select wrong");
  hold_a: assert property (stall_s |=> $stable(ser_word)) else $error("word moved in stall");
endmodule : sermode_properties

bind serializer_mode_control sermode_properties chk (.mclk(mclk), .rst(rst),
  .asi_transport_select(asi_transport_select), .line_rate_select(line_rate_select),
  .input_width_select(input_width_select), .test_host_select(test_host_select),
  .processing_master_enable(processing_master_enable), .ser_ready(ser_ready),
  .video_coding_enable(video_coding_enable), .serial_out_enable(serial_out_enable),
  .ser_word(ser_word), .cfg(cfg), .serial_out_pair_oe(serial_out_pair_oe));

// file: sim/word_sink.sv
`timescale 1ns/1ps
module word_sink (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic stall,
  output logic      ser_ready
);
  logic [31:0] s = 32'h0bad_5eed;
  // Random stalls stress the output hold path
  always @(posedge mclk) begin
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    ser_ready <= !rst && !stall && s[0];
  end
endmodule : word_sink

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic                   mclk, rst, stall, pin_valid, pin_ready, reg_wr, reg_rd, ser_ready, rdy;
  logic                   o, oe, b0;
  logic [6:0]             pins, dis, f;
  logic [3:0]             reg_addr;
  logic [31:0]            reg_wdata, reg_rdata, rnd, d;
  logic [19:0]            pin_data, exp_q[$];
  logic [15:0]            m;
  sermode_pkg::word_t     ser_word;
  sermode_pkg::mode_cfg_t cfg;
  int                     mismatches, samples_checked;
  serializer_mode_control dut (.mclk(mclk), .rst(rst), .asi_transport_select(pins[6]),
    .line_rate_select(pins[5]), .input_width_select(pins[4]),
    .processing_master_enable(pins[3]), .video_coding_enable(pins[2]),
    .serial_out_enable(pins[1]), .test_host_select(pins[0]), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_valid(pin_valid), .pin_ready(pin_ready), .pin_data(pin_data), .ser_word(ser_word),
    .ser_ready(ser_ready), .cfg(cfg), .serial_out_pair_o(o), .serial_out_pair_oe(oe));
  word_sink sink (.mclk(mclk), .rst(rst), .stall(stall), .ser_ready(ser_ready));
  function automatic logic [31:0] xs(logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  task automatic cmp(string what, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask : cmp
  task automatic wr(logic [3:0] a, logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task automatic rd(logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge mclk);
  endtask : rd
  // Offers every third edge so the lagging ready flag is current
  task automatic push(int n);
    repeat (n) begin
      rnd = xs(rnd);
      #1 rdy = pin_ready;
      @(posedge mclk);
      pin_data <= rnd[19:0];
      pin_valid <= rdy | stall;
      if (rdy) exp_q.push_back(pins[4] ? rnd[19:0] : {10'h000, rnd[9:0]});
      @(posedge mclk);
      pin_valid <= 1'b0;
      @(posedge mclk);
    end
  endtask : push
  task automatic end_sim();
    if (mismatches == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  always @(posedge mclk) begin
    if (!rst && ser_word.valid === 1'b1 && ser_ready === 1'b1) begin
      cmp("ser_word", exp_q.size() ? {12'h000, exp_q.pop_front()} : 32'hffff_ffff,
        {12'h000, ser_word.data});
      // Line bit trails the word stage by one edge
      cmp("serial_out_pair_o", {31'h0, pins[1] & b0}, {31'h0, o});
    end
    b0 <= ser_word.data[0];
  end
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
  initial begin
    {rst, stall, pin_valid, reg_wr, reg_rd, pins, reg_addr, reg_wdata, pin_data} = '1;
    {stall, pin_valid, reg_wr, reg_rd, pins} = '0;
    rnd = 32'h8082_cb6d;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    rd(4'h0);
    cmp("feature_disable_reg", 32'h0000_0000, d);
    for (int i = 0; i < 128; i++) begin
      rnd = xs(rnd);
      pins <= i[6:0];
      dis = rnd[6:0];
      wr(4'h0, rnd);
      wr(4'h2, ~rnd);
      wr(4'h9, rnd);
      rd(4'h0);
      cmp("feature_disable_reg", {25'h0, dis}, d);
      rd(4'h9);
      cmp("unmapped", 32'h0000_0000, d);
      f = (pins[2] && !pins[6] && pins[3]) ? ~dis & (pins[5] ? 7'h67 : 7'h7e) : 7'h00;
      rd(4'h2);
      cmp("feat_active", {25'h0, f}, d);
      // Transport mode ignores the width pin, so the wide flag stays low
      m = {pins[6] && pins[5] && !pins[2], pins[2] && !pins[6], pins[5],
        pins[4] && !(pins[6] && pins[5] && !pins[2]), pins[2] && !pins[6],
        pins[6] && pins[5] && !pins[2], pins[5], pins[1], !pins[0], f};
      cmp("cfg", {16'h0, m}, {16'h0, cfg});
      cmp("serial_out_pair_oe", {31'h0, pins[1]}, {31'h0, oe});
    end
    for (int w = 0; w < 2; w++) begin
      pins <= w ? 7'h02 : 7'h12;
      stall <= 1'b1;
      repeat (4) @(posedge mclk);
      push(14);
      stall <= 1'b0;
      push(20);
      repeat (200) if (exp_q.size() != 0) @(posedge mclk);
    end
    cmp("words_left", 32'h0000_0000, exp_q.size());
    end_sim();
  end
endmodule : tb_top
